//--- hdl/cache_maint_params.svh
// constants for the cache maintenance and lockdown block
`ifndef CACHE_MAINT_PARAMS_SVH
`define CACHE_MAINT_PARAMS_SVH
// register offsets (byte addresses)
`define CM_OFF_SYNC        12'h730
`define CM_OFF_INV_PA      12'h770
`define CM_OFF_INV_WAY     12'h77C
`define CM_OFF_CLN_PA      12'h7B0
`define CM_OFF_CLN_IDX     12'h7B8
`define CM_OFF_CLN_WAY     12'h7BC
`define CM_OFF_CI_PA       12'h7F0
`define CM_OFF_CI_IDX      12'h7F8
`define CM_OFF_CI_WAY      12'h7FC
`define CM_OFF_D_LOCK      12'h900
`define CM_OFF_I_LOCK      12'h904
`define CM_OFF_STATUS      12'h908
// field positions
`define CM_WAY_MSB         31
`define CM_WAY_LSB         29
`define CM_LINE_LSB        5
// reset values
`define CM_LOCK_RST        8'h00
// each background step covers one index of one way
`define CM_STEP_CYCLES     2
`endif

//--- hdl/cache_maint_pkg.sv
// types for the cache maintenance and lockdown block
package cache_maint_pkg;
  typedef enum logic [1:0] {
    OP_CLEAN,
    OP_INV,
    OP_CLEAN_INV
  } op_kind_e;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DRAIN,
    ST_LINE,
    ST_WAIT_EMPTY,
    ST_WAY
  } maint_state_e;
endpackage

//--- hdl/cache_maintenance_lockdown.sv
// cache maintenance sequencer and way lockdown registers
//
// Functional notes
// - clean-and-invalidate by way/index writes back a dirty valid line, then invalidates.
// - clean-and-invalidate by address writes back a dirty valid line, then invalidates.
// - clean-and-invalidate by way cleans and invalidates ways in background, ways locked.
// - every maintenance request first drains the internal buffers.
// - maintenance runs whether the cache enable bit is set or not.
// - line and sync operations stall the requesting port until done.
// - way operations run in background; the port is not stalled.
// - lookups continue into ways under background operation.
// - a request arriving while one is busy is ignored.
// - ways under background operation are treated as locked.
// - line operand is a full 32-bit address or way-plus-index word; the address form keeps only bits 31..5 and forces bits 4..0 to zero.
// - way number sits in bits 31..29; other unused bits are zero.
// - index width follows the configured way size.
// - line maintenance registers always read zero.
// - way operations act on ways whose low eight data bits are one.
// - way bits read one while pending and clear when that way is done.
// - separate data and instruction lockdown settings.
// - linefill victim chosen only among unlocked ways.
// - all ways locked: fill is fetched but not written to the cache.
// - all ways locked: write-allocate accesses proceed without allocation.
// - sync drains store, victim and alloc buffers; done once all are empty.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "cache_maint_params.svh"

module cache_maintenance_lockdown #(
  parameter int WAYS      = 8,
  parameter int IDX_BITS  = 8,
  parameter int STEP_CYC  = `CM_STEP_CYCLES
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // register port
  input  wire logic [11:0]         addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [31:0]         rdata_o,
  output logic                     stall_o,
  // cache enable, ignored by maintenance
  input  wire logic                cache_en_i,
  // buffer state from the datapath
  input  wire logic                store_buf_empty_i,
  input  wire logic                victim_buf_empty_i,
  input  wire logic                alloc_buf_empty_i,
  output logic                     drain_req_o,
  // line access to tag array
  output logic                     line_req_o,
  output logic      [2:0]          line_way_o,
  output logic      [IDX_BITS-1:0] line_idx_o,
  output logic      [31:0]         line_addr_o,
  output logic                     line_by_addr_o,
  output logic                     line_clean_o,
  output logic                     line_inv_o,
  input  wire logic                line_done_i,
  // linefill allocation
  input  wire logic                miss_i,
  input  wire logic                miss_instr_i,
  input  wire logic [2:0]          rand_way_i,
  output logic                     alloc_ok_o,
  output logic      [2:0]          victim_way_o,
  output logic      [WAYS-1:0]     lock_mask_o
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  logic wr_sync, wr_line, wr_way;
  logic line_pa;
  cache_maint_pkg::op_kind_e wr_kind;
  always_comb
  begin
    wr_sync = wr_i && hit(addr_i, `CM_OFF_SYNC);
    wr_line = wr_i && (hit(addr_i, `CM_OFF_INV_PA) || hit(addr_i, `CM_OFF_CLN_PA) ||
              hit(addr_i, `CM_OFF_CLN_IDX) || hit(addr_i, `CM_OFF_CI_PA) || hit(addr_i, `CM_OFF_CI_IDX));
    wr_way  = wr_i && (hit(addr_i, `CM_OFF_INV_WAY) || hit(addr_i, `CM_OFF_CLN_WAY) ||
              hit(addr_i, `CM_OFF_CI_WAY));
    line_pa = hit(addr_i, `CM_OFF_INV_PA) || hit(addr_i, `CM_OFF_CLN_PA) || hit(addr_i, `CM_OFF_CI_PA);
    if (hit(addr_i, `CM_OFF_INV_PA) || hit(addr_i, `CM_OFF_INV_WAY))
      wr_kind = cache_maint_pkg::OP_INV;
    else if (hit(addr_i, `CM_OFF_CLN_PA) || hit(addr_i, `CM_OFF_CLN_IDX) || hit(addr_i, `CM_OFF_CLN_WAY))
      wr_kind = cache_maint_pkg::OP_CLEAN;
    else
      wr_kind = cache_maint_pkg::OP_CLEAN_INV;
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  cache_maint_pkg::maint_state_e state;
  cache_maint_pkg::op_kind_e     kind;
  logic [WAYS-1:0]     way_pend;
  logic [WAYS-1:0]     way_sel;
  logic [2:0]          cur_way;
  logic [IDX_BITS-1:0] cur_idx;
  logic [7:0]          step_cnt;
  logic                after_line;
  logic                op_is_way;
  logic                bufs_empty;
  logic                start;

  assign bufs_empty = store_buf_empty_i && victim_buf_empty_i && alloc_buf_empty_i;
  // cache_en_i does not gate any request
  assign start = (state == cache_maint_pkg::ST_IDLE) && (wr_sync || wr_line || wr_way);

  function automatic logic [2:0] first_way(input logic [WAYS-1:0] m);
    first_way = 3'h0;
    for (int k = WAYS - 1; k >= 0; k--)
      if (m[k])
        first_way = 3'(k);
  endfunction

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state       <= cache_maint_pkg::ST_IDLE;
      kind        <= cache_maint_pkg::OP_CLEAN;
      op_is_way   <= 1'b0;
      after_line  <= 1'b0;
      line_req_o  <= 1'b0;
      line_way_o  <= 3'h0;
      line_idx_o  <= '0;
      line_addr_o <= 32'h0;
      line_by_addr_o <= 1'b0;
      line_clean_o <= 1'b0;
      line_inv_o  <= 1'b0;
      way_sel     <= '0;
      cur_way     <= 3'h0;
      cur_idx     <= '0;
      step_cnt    <= 8'h00;
    end
    else
    begin
      case (state)
        cache_maint_pkg::ST_IDLE:
        begin
          if (start)
          begin
            state     <= cache_maint_pkg::ST_DRAIN;
            kind      <= wr_kind;
            op_is_way <= wr_way;
            after_line <= wr_line;
            // operand: address form or way in 31..29 plus index
            line_addr_o <= {wdata_i[31:`CM_LINE_LSB], 5'h00};
            line_way_o  <= wdata_i[`CM_WAY_MSB:`CM_WAY_LSB];
            line_idx_o  <= wdata_i[`CM_LINE_LSB +: IDX_BITS];
            line_by_addr_o <= line_pa;
            way_sel   <= wr_way ? wdata_i[WAYS-1:0] : '0;
          end
        end
        cache_maint_pkg::ST_DRAIN:
        begin
          if (bufs_empty)
          begin
            if (after_line)
            begin
              state        <= cache_maint_pkg::ST_LINE;
              line_req_o   <= 1'b1;
              // clean-and-invalidate asks for both write-back and invalidate
              line_clean_o <= (kind != cache_maint_pkg::OP_INV);
              line_inv_o   <= (kind != cache_maint_pkg::OP_CLEAN);
            end
            else if (op_is_way && (way_sel != '0))
            begin
              state   <= cache_maint_pkg::ST_WAY;
              cur_way <= first_way(way_sel);
              cur_idx <= '0;
              step_cnt <= 8'h00;
            end
            else
              state <= cache_maint_pkg::ST_IDLE;
          end
        end
        cache_maint_pkg::ST_LINE:
        begin
          if (line_done_i)
          begin
            line_req_o <= 1'b0;
            state      <= cache_maint_pkg::ST_WAIT_EMPTY;
          end
        end
        cache_maint_pkg::ST_WAIT_EMPTY:
        begin
          // write-back must leave the victim buffer before the port is released
          if (bufs_empty)
            state <= cache_maint_pkg::ST_IDLE;
        end
        cache_maint_pkg::ST_WAY:
        begin
          // walk every index of each selected way
          line_by_addr_o <= 1'b0;
          line_way_o     <= cur_way;
          line_idx_o     <= cur_idx;
          line_clean_o   <= (kind != cache_maint_pkg::OP_INV);
          line_inv_o     <= (kind != cache_maint_pkg::OP_CLEAN);
          if (step_cnt == 8'(STEP_CYC - 1))
          begin
            step_cnt <= 8'h00;
            if (cur_idx == '1)
            begin
              cur_idx <= '0;
              way_sel[cur_way] <= 1'b0;
              if ((way_sel & ~(WAYS'(1) << cur_way)) == '0)
                state <= cache_maint_pkg::ST_IDLE;
              else
                cur_way <= first_way(way_sel & ~(WAYS'(1) << cur_way));
            end
            else
              cur_idx <= cur_idx + 1'b1;
          end
          else
            step_cnt <= step_cnt + 8'h01;
        end
        default:
          state <= cache_maint_pkg::ST_IDLE;
      endcase
    end
  end

  // pending bits clear as each way finishes
  assign way_pend = way_sel;

  // line and sync hold the port; way operations never do
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      stall_o <= 1'b0;
    else if (start)
      stall_o <= !wr_way;
    else if ((state == cache_maint_pkg::ST_DRAIN && bufs_empty && !after_line) ||
             (state == cache_maint_pkg::ST_WAIT_EMPTY && bufs_empty))
      stall_o <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      drain_req_o <= 1'b0;
    else
      drain_req_o <= start || (state == cache_maint_pkg::ST_DRAIN && !bufs_empty);
  end

  // ----------------------------------------
  // lockdown
  // ----------------------------------------
  logic [WAYS-1:0] d_lock, i_lock;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      d_lock <= WAYS'(`CM_LOCK_RST);
      i_lock <= WAYS'(`CM_LOCK_RST);
    end
    else if (wr_i)
    begin
      if (hit(addr_i, `CM_OFF_D_LOCK))
        d_lock <= wdata_i[WAYS-1:0];
      if (hit(addr_i, `CM_OFF_I_LOCK))
        i_lock <= wdata_i[WAYS-1:0];
    end
  end

  // lookups are never blocked here; only allocation is restricted
  logic [WAYS-1:0] eff_lock;
  logic [2:0]      pick;
  logic            any_free;
  always_comb
  begin
    eff_lock = (miss_instr_i ? i_lock : d_lock) | way_pend;
    any_free = (eff_lock != '1);
    pick     = rand_way_i;
    // next unlocked way at or after the random pointer
    for (int k = WAYS - 1; k >= 0; k--)
      if (!eff_lock[3'(32'(rand_way_i) + k) % WAYS])
        pick = 3'((32'(rand_way_i) + k) % WAYS);
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      alloc_ok_o   <= 1'b0;
      victim_way_o <= 3'h0;
      lock_mask_o  <= '0;
    end
    else
    begin
      lock_mask_o <= eff_lock;
      // no free way: fill still fetched, nothing allocated
      alloc_ok_o   <= miss_i && any_free;
      victim_way_o <= pick;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= 32'h0;
    else if (rd_i)
    begin
      // polled way registers show pending ways line registers read zero
      if (hit(addr_i, `CM_OFF_INV_WAY) || hit(addr_i, `CM_OFF_CLN_WAY) || hit(addr_i, `CM_OFF_CI_WAY))
        rdata_o <= 32'(way_pend);
      else if (hit(addr_i, `CM_OFF_D_LOCK))
        rdata_o <= 32'(d_lock);
      else if (hit(addr_i, `CM_OFF_I_LOCK))
        rdata_o <= 32'(i_lock);
      else if (hit(addr_i, `CM_OFF_STATUS))
        rdata_o <= {29'h0, cache_en_i, stall_o, (state != cache_maint_pkg::ST_IDLE)};
      else
        rdata_o <= 32'h0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence way_start_s;
    start && wr_way;
  endsequence

  busy_ignore_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state != cache_maint_pkg::ST_IDLE && wr_way) |=> $stable(way_sel) || $fell(|way_sel) ||
      (way_sel == ($past(way_sel) & ~(WAYS'(1) << $past(cur_way)))))
    else $error("busy request changed way selection");
  way_nostall_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    way_start_s |=> !stall_o)
    else $error("way operation stalled the port");
  line_stall_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (start && wr_line) |=> stall_o until (state == cache_maint_pkg::ST_IDLE))
    else $error("line operation released port early");
  drain_first_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    start |=> state == cache_maint_pkg::ST_DRAIN)
    else $error("request did not drain first");
  ci_both_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(line_req_o) && kind == cache_maint_pkg::OP_CLEAN_INV |-> line_clean_o && line_inv_o)
    else $error("clean-invalidate missing a step");
  pend_lock_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (way_pend[0] && !miss_instr_i) |=> lock_mask_o[0] || !way_pend[0])
    else $error("pending way not locked");
  line_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    rd_i && hit(addr_i, `CM_OFF_CI_PA) |=> rdata_o == 32'h0)
    else $error("line register read nonzero");
  all_locked_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (miss_i && eff_lock == '1) |=> !alloc_ok_o)
    else $error("allocated with all ways locked");
  victim_free_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (miss_i && any_free) |=> !lock_mask_o[victim_way_o] || $changed(lock_mask_o))
    else $error("victim is a locked way");
  sync_done_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state == cache_maint_pkg::ST_DRAIN && bufs_empty && !after_line && !op_is_way) |=>
      state == cache_maint_pkg::ST_IDLE ##0 !stall_o)
    else $error("sync not completed on empty buffers");

endmodule

//--- bench/datapath_model.sv
// behavioural datapath: buffers that drain on request and a tag array that answers line requests
`timescale 1ns/1ps

module datapath_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // control from the bench
  input  wire logic       fill_i,
  input  wire logic [3:0] delay_i,
  // maintenance side
  input  wire logic       drain_req_i,
  input  wire logic       line_req_i,
  output logic            empty_o,
  output logic            line_done_o
);
  logic [3:0] dcnt;
  logic [3:0] lcnt;

  // buffers refill on traffic and empty some cycles after a drain request
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      empty_o <= 1'b0;
      dcnt    <= 4'h0;
    end
    else if (fill_i)
    begin
      empty_o <= 1'b0;
      dcnt    <= 4'h0;
    end
    else if (drain_req_i && !empty_o)
    begin
      if (dcnt == delay_i)
        empty_o <= 1'b1;
      else
        dcnt <= dcnt + 4'h1;
    end
  end

  // one done pulse per line request, after the programmed delay
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      line_done_o <= 1'b0;
      lcnt        <= 4'h0;
    end
    else
    begin
      line_done_o <= 1'b0;
      if (!line_req_i)
        lcnt <= 4'h0;
      else if (lcnt == delay_i)
      begin
        line_done_o <= 1'b1;
        lcnt        <= 4'hF;
      end
      else if (lcnt != 4'hF)
        lcnt <= lcnt + 4'h1;
    end
  end
endmodule

//--- bench/cache_maintenance_lockdown_test.sv
// self-checking bench for the maintenance sequencer and lockdown
`timescale 1ns/1ps
`include "cache_maint_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end

module cache_maintenance_lockdown_test;
  logic        clk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0, cache_en_i = 1, fill = 0;
  logic        miss_i = 0, miss_instr_i = 0, line_done, empty, stall_o, drain_req_o;
  logic        line_req_o, line_by_addr_o, line_clean_o, line_inv_o, alloc_ok_o;
  logic [11:0] addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, line_addr_o, rd_val;
  logic [2:0]  rand_way_i = 0, line_way_o, victim_way_o;
  logic [1:0]  line_idx_o;
  logic [7:0]  lock_mask_o, mask, dl, il, ex;
  logic [3:0]  delay = 4'h6;
  integer      seed = 20529, bad_count = 0, compares = 0, i, n;
  logic [11:0] way_off [3] = '{`CM_OFF_CI_WAY, `CM_OFF_INV_WAY, `CM_OFF_CLN_WAY};
  // line registers and the expected {clean, invalidate, by address} for each
  logic [11:0] line_off [5] = '{`CM_OFF_CI_IDX, `CM_OFF_CI_PA, `CM_OFF_CLN_IDX, `CM_OFF_INV_PA, `CM_OFF_CLN_PA};
  logic [2:0]  line_exp [5] = '{3'b110, 3'b111, 3'b100, 3'b011, 3'b101};

  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) rand_way_i <= 3'($random(seed));

  cache_maintenance_lockdown #(.WAYS(8), .IDX_BITS(2), .STEP_CYC(2)) cache_maintenance_lockdown_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .stall_o(stall_o), .cache_en_i(cache_en_i), .store_buf_empty_i(empty),
    .victim_buf_empty_i(empty), .alloc_buf_empty_i(empty), .drain_req_o(drain_req_o),
    .line_req_o(line_req_o), .line_way_o(line_way_o), .line_idx_o(line_idx_o), .line_addr_o(line_addr_o),
    .line_by_addr_o(line_by_addr_o), .line_clean_o(line_clean_o), .line_inv_o(line_inv_o),
    .line_done_i(line_done), .miss_i(miss_i), .miss_instr_i(miss_instr_i), .rand_way_i(rand_way_i),
    .alloc_ok_o(alloc_ok_o), .victim_way_o(victim_way_o), .lock_mask_o(lock_mask_o));

  datapath_model datapath_model_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .fill_i(fill), .delay_i(delay), .drain_req_i(drain_req_o),
    .line_req_i(line_req_o), .empty_o(empty), .line_done_o(line_done));

  // operand in way-plus-index form, unused bits zero
  function automatic logic [31:0] way_idx(input logic [2:0] w, input logic [1:0] x);
    return {w, 22'h0, x, 5'h00};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
  endtask

  task automatic wait_cyc(input integer c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask

  // traffic leaves the buffers full before the first sync and each line request
  task automatic refill;
    @(posedge clk_i) fill <= 1'b1;
    @(posedge clk_i) fill <= 1'b0;
  endtask

  task automatic wait_stall_low;
    n = 0;
    while (stall_o !== 1'b0 && n < 100) begin wait_cyc(1); n++; end
    `CHK(stall_o, 1'b0)
    `CHK(empty, 1'b1)
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin #200000; bad_count++; test_done; end

  initial
  begin
    wait_cyc(20);
    arst_n_i = 1'b1;
    wait_cyc(2);
    rd(`CM_OFF_D_LOCK); `CHK(rd_val, 32'h0)
    rd(`CM_OFF_I_LOCK); `CHK(rd_val, 32'h0)
    rd(12'h004); `CHK(rd_val, 32'h0)
    // sync stalls until all buffers have emptied
    refill;
    wr(`CM_OFF_SYNC, 32'h0);
    wait_cyc(3);
    `CHK({stall_o, drain_req_o, empty}, 3'b110)
    wait_stall_low;
    // line operations of every kind, both operand forms, cache disabled on odd passes
    for (i = 0; i < 5; i++)
    begin
      mask = 8'($random(seed));
      cache_en_i <= i[0] ? 1'b0 : 1'b1;
      delay <= 4'h2 + i[3:0];
      refill;
      if (!line_exp[i][0]) wr(line_off[i], way_idx(mask[2:0], mask[4:3]));
      else wr(line_off[i], {25'($random(seed)), mask[4:3], 5'h00});
      n = 0;
      while (line_req_o !== 1'b1 && n < 50) begin wait_cyc(1); n++; end
      `CHK({stall_o, line_clean_o, line_inv_o, line_by_addr_o}, {1'b1, line_exp[i]})
      `CHK(line_idx_o, mask[4:3])
      if (!line_exp[i][0]) `CHK({line_way_o, line_idx_o}, {mask[2:0], mask[4:3]})
      else `CHK(line_addr_o, wdata_i)
      rd(line_off[i]); `CHK(rd_val, 32'h0)
      wait_stall_low;
      `CHK(line_req_o, 1'b0)
    end
    cache_en_i <= 1'b1;
    // background way operations, each of the three kinds
    for (i = 0; i < 3; i++)
    begin
      mask = 8'($random(seed)) | 8'h81;
      wr(way_off[i], {24'h0, mask});
      wait_cyc(2);
      `CHK(stall_o, 1'b0)
      `CHK(lock_mask_o, mask)
      wr(`CM_OFF_SYNC, 32'h0);
      wait_cyc(2);
      `CHK(stall_o, 1'b0)
      rd(way_off[i]); `CHK(rd_val[7:0], mask)
      wr(way_off[(i + 1) % 3], {24'h0, ~mask});
      rd(way_off[i]); `CHK(rd_val[7:0] & ~mask, 8'h00)
      n = 0;
      while (rd_val !== 32'h0 && n < 200) begin rd(way_off[i]); n++; end
      `CHK(rd_val, 32'h0)
      wait_cyc(2);
      `CHK(lock_mask_o, 8'h00)
    end
    // lockdown selection and victim choice, all ways locked last
    for (i = 0; i < 6; i++)
    begin
      dl = (i == 5) ? 8'hFF : 8'($random(seed));
      il = (i == 5) ? 8'hFF : 8'($random(seed));
      wr(`CM_OFF_D_LOCK, {24'h0, dl});
      wr(`CM_OFF_I_LOCK, {24'h0, il});
      rd(`CM_OFF_D_LOCK); `CHK(rd_val, {24'h0, dl})
      miss_i <= 1'b1;
      miss_instr_i <= i[0];
      ex = i[0] ? il : dl;
      wait_cyc(4);
      `CHK(lock_mask_o, ex)
      `CHK(alloc_ok_o, (ex != 8'hFF))
      if (alloc_ok_o === 1'b1) `CHK(ex[victim_way_o], 1'b0)
      miss_i <= 1'b0;
    end
    test_done;
  end
endmodule
